/* inc/sfpi_consts.svh */
// Constants for the serial flash pin interface
`ifndef SFPI_CONSTS_SVH
`define SFPI_CONSTS_SVH

`define SFPI_SYNC_STAGES 2
`define SFPI_PIN_COUNT   6
`define SFPI_PIN_RST     6'h1F
`define SFPI_OE_OFF      4'hF
`define SFPI_MASK_SINGLE 4'h2
`define SFPI_MASK_DUAL   4'h3
`define SFPI_MASK_QUAD   4'hF
`define SFPI_NIBBLE_RST  4'h0

`endif

/* inc/sfpi_pkg.sv */
// Types for the serial flash pin interface
package sfpi_pkg;

    typedef enum logic [1:0] {
        LANE_SINGLE,
        LANE_DUAL,
        LANE_QUAD
    } sfpi_lane_t;

    typedef enum logic [1:0] {
        ST_UNARMED,
        ST_DESEL,
        ST_ACTIVE,
        ST_HOLD
    } sfpi_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] dl;
    } sfpi_pins_t;

endpackage : sfpi_pkg

/* design/sfpi_top.sv */
// Pin-level logic of the serial flash: select, power mode, hold, lanes, write protect
`timescale 1ns/10ps
`include "sfpi_consts.svh"

module sfpi_top (
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic                data_line_0_i,
    output logic                     data_line_0_o,
    output logic                     data_line_0_oe_n,
    input  wire logic                data_line_1_i,
    output logic                     data_line_1_o,
    output logic                     data_line_1_oe_n,
    input  wire logic                data_line_2_i,
    output logic                     data_line_2_o,
    output logic                     data_line_2_oe_n,
    input  wire logic                data_line_3_i,
    output logic                     data_line_3_o,
    output logic                     data_line_3_oe_n,
    input  wire sfpi_pkg::sfpi_lane_t lane_mode,
    input  wire logic [3:0]          tx_data,
    input  wire logic                tx_enable,
    input  wire logic                busy_internal,
    input  wire logic                quad_io_enable,
    input  wire logic                status_lock_upper_bit,
    input  wire logic                status_lock_lower_bit,
    output logic [3:0]               rx_data,
    output logic                     rx_valid,
    output logic                     frame_start,
    output logic                     selected,
    output logic                     standby,
    output logic                     hold_active,
    output logic                     quad_denied,
    output logic                     status_write_block,
    output logic                     area_protect_block
);

    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0]                         rst_sync_q;
    logic                               rst_n;
    sfpi_pkg::sfpi_pins_t               pins_raw;
    logic [`SFPI_PIN_COUNT-1:0]         sync1_q;
    logic [`SFPI_PIN_COUNT-1:0]         sync2_q;
    sfpi_pkg::sfpi_pins_t               pins;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign pins_raw = {cs_n, sclk, data_line_3_i, data_line_2_i, data_line_1_i, data_line_0_i};

    // Chip select resets low: only a real high seen after reset can arm the part
    localparam logic [`SFPI_PIN_COUNT-1:0] PIN_RST = `SFPI_PIN_RST;
    genvar gi;
    generate
        for (gi = 0; gi < `SFPI_PIN_COUNT; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[gi] <= PIN_RST[gi];
                    sync2_q[gi] <= PIN_RST[gi];
                end else begin
                    sync1_q[gi] <= pins_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign pins = sfpi_pkg::sfpi_pins_t'(sync2_q);

    // ----------------------------------------
    // Clock edge detection and lane choice
    // ----------------------------------------
    logic                 sclk_prev_q;
    logic                 sclk_prev_d;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 hold_en;
    logic                 wp_en;
    sfpi_pkg::sfpi_lane_t eff_lane;

    assign sclk_prev_d = pins.sclk;
    assign sclk_rise   = pins.sclk & ~sclk_prev_q;
    assign sclk_fall   = ~pins.sclk & sclk_prev_q;
    assign hold_en     = ~quad_io_enable;
    assign wp_en       = ~quad_io_enable;
    // Quad request without quad enable falls back to one lane
    assign eff_lane    = (lane_mode == sfpi_pkg::LANE_QUAD && !quad_io_enable) ?
                         sfpi_pkg::LANE_SINGLE : lane_mode;

    // ----------------------------------------
    // Select, power and hold state
    // ----------------------------------------
    sfpi_pkg::sfpi_state_t st_q;
    sfpi_pkg::sfpi_state_t st_d;

    always_comb begin
        st_d = st_q;
        case (st_q)
            sfpi_pkg::ST_UNARMED: begin
                if (pins.cs_n) st_d = sfpi_pkg::ST_DESEL;
            end
            sfpi_pkg::ST_DESEL: begin
                if (!pins.cs_n) st_d = sfpi_pkg::ST_ACTIVE;
            end
            sfpi_pkg::ST_ACTIVE: begin
                if (pins.cs_n) begin
                    st_d = sfpi_pkg::ST_DESEL;
                end else if (hold_en && !pins.dl[3] && !pins.sclk) begin
                    st_d = sfpi_pkg::ST_HOLD;
                end
            end
            sfpi_pkg::ST_HOLD: begin
                if (pins.cs_n) begin
                    st_d = sfpi_pkg::ST_DESEL;
                end else if (!hold_en || (pins.dl[3] && !pins.sclk)) begin
                    // Quad enable drops a pending hold at once, whatever the clock
                    st_d = sfpi_pkg::ST_ACTIVE;
                end
            end
            default: st_d = sfpi_pkg::ST_UNARMED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= sfpi_pkg::ST_UNARMED;
            sclk_prev_q <= 1'b1;
        end else begin
            st_q        <= st_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    // Internal write keeps running through deselect and hold
    assign selected    = (st_q == sfpi_pkg::ST_ACTIVE) || (st_q == sfpi_pkg::ST_HOLD);
    assign standby     = !selected && !busy_internal;
    assign hold_active = (st_q == sfpi_pkg::ST_HOLD);

    // ----------------------------------------
    // Receive, transmit and protection
    // ----------------------------------------
    logic [3:0] rx_data_q, rx_data_d;
    logic       rx_valid_q, rx_valid_d;
    logic       frame_q, frame_d;
    logic [3:0] out_q, out_d;
    logic [3:0] oe_n_q, oe_n_d;
    logic [3:0] lane_mask;
    logic       qden_q, qden_d;
    logic       swb_q, swb_d;
    logic       apb_q, apb_d;

    always_comb begin
        case (eff_lane)
            sfpi_pkg::LANE_DUAL: lane_mask = `SFPI_MASK_DUAL;
            sfpi_pkg::LANE_QUAD: lane_mask = `SFPI_MASK_QUAD;
            default:             lane_mask = `SFPI_MASK_SINGLE;
        endcase
    end

    always_comb begin
        rx_data_d  = rx_data_q;
        rx_valid_d = 1'b0;
        out_d      = out_q;
        oe_n_d     = oe_n_q;
        frame_d    = (st_q == sfpi_pkg::ST_DESEL) && (st_d == sfpi_pkg::ST_ACTIVE);
        // Edges only count while active, so hold freezes the transfer
        if (st_q == sfpi_pkg::ST_ACTIVE && st_d == sfpi_pkg::ST_ACTIVE && sclk_rise) begin
            rx_valid_d = 1'b1;
            case (eff_lane)
                sfpi_pkg::LANE_DUAL: rx_data_d = {2'h0, pins.dl[1:0]};
                sfpi_pkg::LANE_QUAD: rx_data_d = pins.dl;
                default:             rx_data_d = {3'h0, pins.dl[0]};
            endcase
        end
        if (st_d != sfpi_pkg::ST_ACTIVE) begin
            oe_n_d = `SFPI_OE_OFF;
        end else if (sclk_fall) begin
            // Mode 3 opens on a falling edge; core leaves tx off then
            oe_n_d = tx_enable ? ~lane_mask : `SFPI_OE_OFF;
            case (eff_lane)
                sfpi_pkg::LANE_DUAL: out_d = {2'h0, tx_data[1:0]};
                sfpi_pkg::LANE_QUAD: out_d = tx_data;
                default:             out_d = {2'h0, tx_data[0], 1'b0};
            endcase
        end
        qden_d = (lane_mode == sfpi_pkg::LANE_QUAD) && !quad_io_enable;
        swb_d  = wp_en && !pins.dl[2] && !status_lock_upper_bit && status_lock_lower_bit;
        apb_d  = swb_d;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_q  <= `SFPI_NIBBLE_RST;
            rx_valid_q <= 1'b0;
            frame_q    <= 1'b0;
            out_q      <= `SFPI_NIBBLE_RST;
            oe_n_q     <= `SFPI_OE_OFF;
            qden_q     <= 1'b0;
            swb_q      <= 1'b0;
            apb_q      <= 1'b0;
        end else begin
            rx_data_q  <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            frame_q    <= frame_d;
            out_q      <= out_d;
            oe_n_q     <= oe_n_d;
            qden_q     <= qden_d;
            swb_q      <= swb_d;
            apb_q      <= apb_d;
        end
    end

    assign rx_data            = rx_data_q;
    assign rx_valid           = rx_valid_q;
    assign frame_start        = frame_q;
    assign quad_denied        = qden_q;
    assign status_write_block = swb_q;
    assign area_protect_block = apb_q;
    assign data_line_0_o      = out_q[0];
    assign data_line_1_o      = out_q[1];
    assign data_line_2_o      = out_q[2];
    assign data_line_3_o      = out_q[3];
    assign data_line_0_oe_n   = oe_n_q[0];
    assign data_line_1_oe_n   = oe_n_q[1];
    assign data_line_2_oe_n   = oe_n_q[2];
    assign data_line_3_oe_n   = oe_n_q[3];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_desel_float: assert property (pins.cs_n |=> oe_n_q == `SFPI_OE_OFF)
        else $error("Outputs driven while deselected");
    a_standby_entry: assert property ($fell(selected) && !busy_internal |-> standby)
        else $error("No standby after deselect");
    a_select_active: assert property (st_q == sfpi_pkg::ST_DESEL && !pins.cs_n |=> selected && frame_start)
        else $error("Select did not activate");
    a_powerup_guard: assert property (st_q == sfpi_pkg::ST_UNARMED |=> !selected && !frame_start)
        else $error("Selected before chip select edge");
    a_rx_on_rise: assert property (rx_valid |-> $past(sclk_rise))
        else $error("Sample not on rising edge");
    a_tx_on_fall: assert property (!sclk_fall && st_d == sfpi_pkg::ST_ACTIVE |=> $stable(out_q))
        else $error("Output changed off falling edge");
    a_quad_drive: assert property (sclk_fall && tx_enable && st_d == sfpi_pkg::ST_ACTIVE
        && eff_lane == sfpi_pkg::LANE_QUAD |=> oe_n_q == 4'h0)
        else $error("Quad lanes not driven");
    a_wp_block: assert property (!quad_io_enable && !pins.dl[2] && !status_lock_upper_bit
        && status_lock_lower_bit |=> status_write_block && area_protect_block)
        else $error("Write protect not applied");
    a_wp_qe_off: assert property (quad_io_enable |=> !status_write_block)
        else $error("Write protect active in quad mode");
    a_hold_start: assert property (st_q == sfpi_pkg::ST_ACTIVE && !pins.cs_n && hold_en
        && !pins.dl[3] && !pins.sclk |=> hold_active ##1 oe_n_q == `SFPI_OE_OFF)
        else $error("Hold did not start");
    a_hold_end: assert property (hold_active && !pins.cs_n && pins.dl[3] && !pins.sclk |=> !hold_active)
        else $error("Hold did not end");
    a_hold_quiet: assert property (hold_active |=> !rx_valid)
        else $error("Sample taken during hold");
    a_qe_no_hold: assert property (quad_io_enable |=> !hold_active)
        else $error("Hold honoured with quad enable");

    c_frame: cover property (frame_start);
    c_hold: cover property (hold_active ##[1:50] !hold_active);
    c_quad_tx: cover property (oe_n_q == 4'h0);
    c_wp: cover property (status_write_block);

endmodule : sfpi_top

/* bench/sfpi_host_model.sv */
// SPI host model driving the flash pins
`timescale 1ns/10ps
module sfpi_host_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] dl,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      h_out,
    output logic [3:0]      h_oe
);
    // ----------------
    // Pin sequences
    // ----------------
    logic [3:0] seen;
    logic [3:0] sent;
    logic       idle_hi;
    int         n_sel;

    initial begin
        cs_n = 1'b0; // Low from power-up on purpose
        sclk = 1'b0;
        h_out = 4'h0;
        h_oe = 4'h0;
        seen = 4'h0;
        sent = 4'h0;
        idle_hi = 1'b0;
        n_sel = 0;
    end

    task automatic sel(input logic mode3);
        idle_hi = mode3;
        @(posedge clk_sys);
        sclk <= mode3;
        cs_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        cs_n <= 1'b0;
        n_sel++;
        repeat (6) @(posedge clk_sys);
    endtask : sel

    task automatic desel();
        @(posedge clk_sys);
        sclk <= idle_hi;
        h_oe <= 4'h0;
        repeat (4) @(posedge clk_sys);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : desel

    // Data moves with the fall so it is stable across the rise
    task automatic bit_x(input logic [3:0] v, input logic [3:0] drv);
        @(posedge clk_sys);
        seen = dl;
        h_out <= v;
        h_oe <= drv;
        sclk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sent = v;
        sclk <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : bit_x

    task automatic pin(input int n, input logic v);
        @(posedge clk_sys);
        h_out[n] <= v;
        h_oe[n] <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask : pin

    task automatic clk_to(input logic v);
        @(posedge clk_sys);
        sclk <= v;
        repeat (5) @(posedge clk_sys);
    endtask : clk_to
endmodule : sfpi_host_model

/* bench/tb_top.sv */
// Self-checking bench for the flash pin block
`timescale 1ns/10ps
module tb_top;
    // ----------------
    // Signals
    // ----------------
    logic                 clk_sys, cs_n, sclk, rx_valid, frame_start, selected, standby;
    logic                 hold_active, quad_denied, status_write_block, area_protect_block;
    logic                 nrst = 1'b0, tx_enable = 1'b0, busy_internal = 1'b0, rx_on = 1'b0;
    logic                 quad_io_enable = 1'b0, status_lock_upper_bit = 1'b0;
    logic                 status_lock_lower_bit = 1'b0;
    logic [3:0]           tx_data = 4'h0, rx_mask = 4'h0, last_q = 4'h0;
    logic [3:0]           rx_data, d_o, oe_n, dl_w, h_out, h_oe;
    sfpi_pkg::sfpi_lane_t lane_mode = sfpi_pkg::LANE_SINGLE;
    int                   errors = 0, compares = 0, n_rx = 0, n_fs = 0, cyc = 0, n0;

    sfpi_top i_sfpi_top (
        .clk_sys, .nrst, .cs_n, .sclk, .lane_mode, .tx_data, .tx_enable, .busy_internal,
        .quad_io_enable, .status_lock_upper_bit, .status_lock_lower_bit,
        .data_line_0_i(dl_w[0]), .data_line_0_o(d_o[0]), .data_line_0_oe_n(oe_n[0]),
        .data_line_1_i(dl_w[1]), .data_line_1_o(d_o[1]), .data_line_1_oe_n(oe_n[1]),
        .data_line_2_i(dl_w[2]), .data_line_2_o(d_o[2]), .data_line_2_oe_n(oe_n[2]),
        .data_line_3_i(dl_w[3]), .data_line_3_o(d_o[3]), .data_line_3_oe_n(oe_n[3]),
        .rx_data, .rx_valid, .frame_start, .selected, .standby, .hold_active,
        .quad_denied, .status_write_block, .area_protect_block
    );
    sfpi_host_model i_sfpi_host_model (.clk_sys, .dl(dl_w), .cs_n, .sclk, .h_out, .h_oe);

    // Lines 2 and 3 have pull-ups; undriven 0 and 1 flip so stale values never match
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            dl_w[n] = !oe_n[n] ? d_o[n] : h_oe[n] ? h_out[n] : (n > 1) ? 1'b1 : ~last_q[n];
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    always @(posedge clk_sys) begin
        last_q <= dl_w;
        cyc <= cyc + 1;
        if (rx_valid) n_rx <= n_rx + 1;
        if (frame_start) n_fs <= n_fs + 1;
        if (rx_valid && rx_on) chk(rx_data & rx_mask, i_sfpi_host_model.sent & rx_mask);
        if (cyc == 5000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    // ----------------
    // One frame: receive four beats, then send
    // ----------------
    task automatic run(input sfpi_pkg::sfpi_lane_t ln, input logic [3:0] m, input logic mode3,
                       input logic [3:0] txd);
        int         k0;
        logic [3:0] om;
        logic [3:0] ex;
        om = (ln == sfpi_pkg::LANE_SINGLE) ? 4'h2 : m;
        ex = (ln == sfpi_pkg::LANE_SINGLE) ? {2'b00, txd[0], 1'b0} : txd;
        lane_mode <= ln;
        rx_mask <= m;
        tx_data <= txd;
        rx_on <= 1'b1;
        i_sfpi_host_model.sel(mode3);
        chk(selected, 1'b1);
        chk(standby, 1'b0);
        chk(quad_denied, 1'b0);
        k0 = n_rx;
        for (int i = 0; i < 4; i++) i_sfpi_host_model.bit_x(4'(9 * i + 6), m);
        repeat (3) @(posedge clk_sys);
        rx_on <= 1'b0;
        tx_enable <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            i_sfpi_host_model.bit_x(4'h0, 4'h0);
            if (i > 0) chk(i_sfpi_host_model.seen & om, ex & om);
            if (i > 0) chk(oe_n, om ^ 4'hF);
        end
        i_sfpi_host_model.desel();
        tx_enable <= 1'b0;
        chk(oe_n, 4'hF);
        chk(8'(n_rx - k0), 8'h07);
    endtask : run

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk(selected, 1'b0);
        chk(oe_n, 4'hF);
        chk(standby, 1'b1);
        busy_internal <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(standby, 1'b0);
        busy_internal <= 1'b0;
        run(sfpi_pkg::LANE_SINGLE, 4'h1, 1'b0, 4'h1);
        run(sfpi_pkg::LANE_SINGLE, 4'h1, 1'b1, 4'h0);
        run(sfpi_pkg::LANE_DUAL, 4'h3, 1'b0, 4'h2);
        quad_io_enable <= 1'b1;
        run(sfpi_pkg::LANE_QUAD, 4'hF, 1'b1, 4'h9);
        quad_io_enable <= 1'b0;
        lane_mode <= sfpi_pkg::LANE_QUAD;
        i_sfpi_host_model.sel(1'b0);
        chk(quad_denied, 1'b1);
        tx_enable <= 1'b1;
        tx_data <= 4'h1;
        i_sfpi_host_model.bit_x(4'h0, 4'h0);
        i_sfpi_host_model.bit_x(4'h0, 4'h0);
        i_sfpi_host_model.pin(3, 1'b0);
        chk(hold_active, 1'b0);
        busy_internal <= 1'b1;
        i_sfpi_host_model.clk_to(1'b0);
        chk(hold_active, 1'b1);
        chk(oe_n, 4'hF);
        chk(standby, 1'b0);
        n0 = n_rx;
        i_sfpi_host_model.bit_x(4'h0, 4'h8);
        i_sfpi_host_model.bit_x(4'h0, 4'h8);
        chk(8'(n_rx - n0), 8'h00);
        i_sfpi_host_model.pin(3, 1'b1);
        chk(hold_active, 1'b1);
        i_sfpi_host_model.clk_to(1'b0);
        chk(hold_active, 1'b0);
        i_sfpi_host_model.bit_x(4'h0, 4'h0);
        i_sfpi_host_model.bit_x(4'h0, 4'h0);
        chk(oe_n, 4'hD);
        tx_enable <= 1'b0;
        quad_io_enable <= 1'b1;
        i_sfpi_host_model.clk_to(1'b0);
        i_sfpi_host_model.pin(3, 1'b0);
        chk(8'(n_rx - n0), 8'h02);
        chk(hold_active, 1'b0);
        busy_internal <= 1'b0;
        i_sfpi_host_model.pin(3, 1'b1);
        for (int k = 0; k < 16; k++) begin
            quad_io_enable <= k[3];
            status_lock_upper_bit <= k[1];
            status_lock_lower_bit <= k[0];
            i_sfpi_host_model.pin(2, k[2]);
            chk(status_write_block, k == 1);
            chk(area_protect_block, k == 1);
        end
        i_sfpi_host_model.desel();
        chk(standby, 1'b1);
        chk(8'(n_fs), 8'(i_sfpi_host_model.n_sel));
        end_sim();
    end
endmodule : tb_top
